// File: verilog/temp_alarm_pkg.sv
// constants, register map and types for the temperature alarm outputs
// assumes an apb slave front end at 32-bit aligned word offsets
package temp_alarm_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CONFIG      = 8'h00;
	localparam logic [7:0] OFS_STATUS      = 8'h04;
	localparam logic [7:0] OFS_MASK        = 8'h08;
	localparam logic [7:0] OFS_LOC_HIGH    = 8'h0c;
	localparam logic [7:0] OFS_LOC_LOW     = 8'h10;
	localparam logic [7:0] OFS_REM_HIGH    = 8'h14;
	localparam logic [7:0] OFS_REM_LOW     = 8'h18;
	localparam logic [7:0] OFS_LOC_FS      = 8'h1c;
	localparam logic [7:0] OFS_REM_FS      = 8'h20;
	localparam logic [7:0] OFS_HYST        = 8'h24;
	localparam logic [7:0] OFS_OFFSET      = 8'h28;
	localparam logic [7:0] OFS_LOC_RESULT  = 8'h2c;
	localparam logic [7:0] OFS_REM_RESULT  = 8'h30;
	localparam logic [7:0] OFS_PINS        = 8'h34;

	// ------------------------------------------------------------
	// status and mask bit positions
	// ------------------------------------------------------------
	localparam int ST_LOC_LOW  = 0;
	localparam int ST_REM_LOW  = 1;
	localparam int ST_OPEN     = 2;
	localparam int ST_REM_HIGH = 3;
	localparam int ST_LOC_HIGH = 4;
	localparam int ST_REM_FS   = 5;
	localparam int ST_LOC_FS   = 6;
	localparam int ST_WIDTH    = 7;

	// config bit: pin acts as second fail-safe output
	localparam int CFG_SECOND_FS = 0;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] FS_LIMIT_RESET = 8'h55;
	localparam logic [7:0] HYST_RESET     = 8'h0a;
	localparam logic [7:0] HIGH_RESET     = 8'h55;
	localparam logic [7:0] LOW_RESET      = 8'h00;
	localparam logic [7:0] ZERO8          = 8'h00;

	// alert response address, 7 bits
	localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;

	// alert handshake states
	typedef enum logic [1:0] {
		ALERT_IDLE    = 2'b00,
		ALERT_LATCHED = 2'b01,
		ALERT_ANSWERED= 2'b11
	} alert_state_type;

endpackage

// File: verilog/temp_compare.sv
// one channel's plain limit comparisons and hysteretic fail-safe comparisons
// assumes signed 8-bit results and limits, updated on result_wr
`timescale 1ns/100ps
module temp_compare
	import temp_alarm_pkg::*;
#(
	parameter int W = 8
)
(
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst,
	// result and limits
	input  wire logic         result_wr,
	input  wire logic [W-1:0] result,
	input  wire logic [W-1:0] high_lim,
	input  wire logic [W-1:0] low_lim,
	input  wire logic [W-1:0] fs_lim,
	input  wire logic [W-1:0] hyst,
	// comparison outcomes
	output logic              over_high,
	output logic              at_low,
	output logic              fs_active_q,
	output logic              sec_active_q
);

	// ------------------------------------------------------------
	// hysteretic comparator
	// ------------------------------------------------------------
	function automatic logic hyst_cmp(input logic act, input logic [W-1:0] t,
		input logic [W-1:0] lim, input logic [W-1:0] h);
		logic signed [W+1:0] rel;
		rel = $signed({{2{lim[W-1]}}, lim}) - $signed({2'b00, h});
		if ($signed(t) > $signed(lim))
			hyst_cmp = 1'b1;
		else if ($signed({{2{t[W-1]}}, t}) <= rel)
			hyst_cmp = 1'b0;
		else
			hyst_cmp = act;
	endfunction

	wire logic fs_d  = hyst_cmp(fs_active_q, result, fs_lim, hyst);   // RL6 RL7
	wire logic sec_d = hyst_cmp(sec_active_q, result, high_lim, hyst); // RL12 RL13

	assign over_high = $signed(result) > $signed(high_lim);  // RL2
	assign at_low    = $signed(result) <= $signed(low_lim);  // RL2

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			fs_active_q  <= 1'b0;
			sec_active_q <= 1'b0;
		end
		else if (result_wr) // RL19
		begin
			fs_active_q  <= fs_d;
			sec_active_q <= sec_d;
		end
	end

endmodule

// File: verilog/apb_regs.sv
// apb slave decode: zero-wait access with error on unmapped address
// assumes a single apb master on core_clk
`timescale 1ns/100ps
module apb_regs
	import temp_alarm_pkg::*;
(
	// apb request
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	// decoded strobes
	output logic             wr_en,
	output logic             rd_en,
	output logic             mapped,
	output logic             pready,
	output logic             pslverr
);

	assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_PINS);
	assign wr_en  = psel && penable && pwrite && mapped;
	assign rd_en  = psel && penable && !pwrite && mapped;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

endmodule

// File: verilog/temp_alarm_outputs.sv
// alarm output logic of a dual-channel temperature monitor
// assumes results and fault strobe from the conversion logic on core_clk,
// alert-response strobe from the smbus engine, apb register access
//
// Behaviour
// (RL1) maskable limit-alarm on limits and open diode
// (RL2) alarm on above high or at/below low
// (RL3) open remote diode drives alarm low
// (RL4) release after address read, status clear, cause gone; the pin does not wait for cause gone, only the return to ALERT_IDLE does
// (RL5) fail-safe output has no mask
// (RL6) fail-safe low when channel above fail-safe limit
// (RL7) fail-safe releases at limit minus hysteresis
// (RL8) fail-safe limits reset to 85 degrees
// (RL9) hysteresis resets to 10, reprogrammable
// (RL10) software keeps fail-safe limits above high limits
// (RL11) shared pin selects alarm or second fail-safe
// (RL12) second fail-safe above high limits, unmasked
// (RL13) second fail-safe releases with same hysteresis
// (RL14) either channel drives both fail-safe outputs
// (RL15) signed offset applied to remote result
// (RL16) software writes summed offsets as one value
// (RL17) active alarm answers alert response with address
// (RL18) open diode at conversion start sets bit 2
// (RL19) comparisons re-evaluated on every result write
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
module temp_alarm_outputs
	import temp_alarm_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary value
)
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// conversion results
	input  wire logic        loc_wr,
	input  wire logic [7:0]  loc_raw,
	input  wire logic        rem_wr,
	input  wire logic [7:0]  rem_raw,
	input  wire logic        conv_start,
	input  wire logic        diode_open,
	// alert response from smbus engine
	input  wire logic        ara_req,
	output logic             ara_ack,
	output logic [7:0]       ara_data,
	// pins, open drain
	output logic             failsafe_overtemp_n,
	output logic             failsafe_overtemp_oe,
	output logic             alarm_pin_n,
	output logic             alarm_pin_oe,
	// interrupt
	output logic             irq
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0]          cfg_q, loc_high_q, loc_low_q, rem_high_q, rem_low_q;
	logic [7:0]          loc_fs_q, rem_fs_q, hyst_q, offset_q, loc_res_q, rem_res_q;
	logic [ST_WIDTH-1:0] status_q, mask_q;
	logic                open_q;
	logic                loc_wr_q, rem_wr_q;
	logic [7:0]          ara_data_q;
	alert_state_type     alert_q, alert_d;

	wire logic wr_en;

	apb_regs u_apb (
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.wr_en   (wr_en),
		.rd_en   (),
		.mapped  (),
		.pready  (pready),
		.pslverr (pslverr)
	);

	function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] ofs);
		wr_hit = en && (a == ofs);
	endfunction

	// ------------------------------------------------------------
	// remote offset correction, saturating
	// ------------------------------------------------------------
	wire logic signed [8:0] rem_sum = $signed({rem_raw[7], rem_raw}) + $signed({offset_q[7], offset_q}); // RL15
	wire logic [7:0] rem_corr = (rem_sum > 9'sd127) ? 8'h7f :
		(rem_sum < -9'sd128) ? 8'h80 : rem_sum[7:0];

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			loc_res_q <= ZERO8;
			rem_res_q <= ZERO8;
			loc_wr_q  <= 1'b0;
			rem_wr_q  <= 1'b0;
		end
		else
		begin
			loc_wr_q <= loc_wr;
			rem_wr_q <= rem_wr;
			if (loc_wr)
				loc_res_q <= loc_raw;
			if (rem_wr)
				rem_res_q <= rem_corr; // RL15
		end
	end

	// ------------------------------------------------------------
	// channel comparators
	// ------------------------------------------------------------
	wire logic loc_over, loc_under, loc_fs, loc_sec;
	wire logic rem_over, rem_under, rem_fs, rem_sec;

	temp_compare u_loc (
		.core_clk     (core_clk),
		.rst          (rst),
		.result_wr    (loc_wr_q),
		.result       (loc_res_q),
		.high_lim     (loc_high_q),
		.low_lim      (loc_low_q),
		.fs_lim       (loc_fs_q),
		.hyst         (hyst_q),
		.over_high    (loc_over),
		.at_low       (loc_under),
		.fs_active_q  (loc_fs),
		.sec_active_q (loc_sec)
	);

	temp_compare u_rem (
		.core_clk     (core_clk),
		.rst          (rst),
		.result_wr    (rem_wr_q),
		.result       (rem_res_q),
		.high_lim     (rem_high_q),
		.low_lim      (rem_low_q),
		.fs_lim       (rem_fs_q),
		.hyst         (hyst_q),
		.over_high    (rem_over),
		.at_low       (rem_under),
		.fs_active_q  (rem_fs),
		.sec_active_q (rem_sec)
	);

	// ------------------------------------------------------------
	// status events, set wins over write-one clear
	// ------------------------------------------------------------
	logic [ST_WIDTH-1:0] ev;
	always_comb
	begin
		ev = '0;
		ev[ST_LOC_LOW]  = loc_wr_q && loc_under; // RL2 RL19
		ev[ST_LOC_HIGH] = loc_wr_q && loc_over;  // RL2
		ev[ST_REM_LOW]  = rem_wr_q && rem_under; // RL2
		ev[ST_REM_HIGH] = rem_wr_q && rem_over;  // RL2
		ev[ST_OPEN]     = conv_start && diode_open; // RL18
		ev[ST_LOC_FS]   = loc_fs;
		ev[ST_REM_FS]   = rem_fs;
	end

	wire logic [ST_WIDTH-1:0] st_clr = wr_hit(wr_en, paddr, OFS_STATUS) ? pwdata[ST_WIDTH-1:0] : '0;
	wire logic [ST_WIDTH-1:0] st_d   = (status_q & ~st_clr) | ev;

	// conditions still present hold alert release off
	wire logic cause_now = loc_over || loc_under || rem_over || rem_under || open_q;
	wire logic alarm_any = |(status_q & ~mask_q);  // RL1

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			status_q <= '0;
			open_q   <= 1'b0;
		end
		else
		begin
			status_q <= st_d;
			if (conv_start)
				open_q <= diode_open; // RL3
		end
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_q      <= ZERO8;
			mask_q     <= '0;
			loc_high_q <= HIGH_RESET;
			loc_low_q  <= LOW_RESET;
			rem_high_q <= HIGH_RESET;
			rem_low_q  <= LOW_RESET;
			loc_fs_q   <= FS_LIMIT_RESET; // RL8
			rem_fs_q   <= FS_LIMIT_RESET; // RL8
			hyst_q     <= HYST_RESET;     // RL9
			offset_q   <= ZERO8;
		end
		else
		begin
			if (wr_hit(wr_en, paddr, OFS_CONFIG))   cfg_q      <= pwdata[7:0];
			if (wr_hit(wr_en, paddr, OFS_MASK))     mask_q     <= pwdata[ST_WIDTH-1:0];
			if (wr_hit(wr_en, paddr, OFS_LOC_HIGH)) loc_high_q <= pwdata[7:0];
			if (wr_hit(wr_en, paddr, OFS_LOC_LOW))  loc_low_q  <= pwdata[7:0];
			if (wr_hit(wr_en, paddr, OFS_REM_HIGH)) rem_high_q <= pwdata[7:0];
			if (wr_hit(wr_en, paddr, OFS_REM_LOW))  rem_low_q  <= pwdata[7:0];
			if (wr_hit(wr_en, paddr, OFS_LOC_FS))   loc_fs_q   <= pwdata[7:0];
			if (wr_hit(wr_en, paddr, OFS_REM_FS))   rem_fs_q   <= pwdata[7:0];
			if (wr_hit(wr_en, paddr, OFS_HYST))     hyst_q     <= pwdata[7:0]; // RL9
			if (wr_hit(wr_en, paddr, OFS_OFFSET))   offset_q   <= pwdata[7:0]; // RL15
		end
	end

	// ------------------------------------------------------------
	// alert latch and alert-response handshake
	// ------------------------------------------------------------
	wire logic second_fs_mode = cfg_q[CFG_SECOND_FS]; // RL11
	wire logic ara_hit = ara_req && (alert_q == ALERT_LATCHED) && !second_fs_mode;

	always_comb
	begin
		alert_d = alert_q;
		case (alert_q)
			ALERT_IDLE:
				if (alarm_any)
					alert_d = ALERT_LATCHED; // RL1
			ALERT_LATCHED:
				if (ara_hit)
					alert_d = ALERT_ANSWERED; // RL17
			ALERT_ANSWERED:
				if (status_q == '0 && !cause_now)
					alert_d = ALERT_IDLE; // RL4
				else if (alarm_any && status_q != '0 && ara_req)
					alert_d = ALERT_ANSWERED;
			default:
				alert_d = ALERT_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			alert_q    <= ALERT_IDLE;
			ara_data_q <= ZERO8;
		end
		else
		begin
			alert_q <= alert_d;
			if (ara_hit)
				ara_data_q <= {DEV_ADDR, 1'b1}; // RL17
		end
	end

	assign ara_ack  = ara_hit;
	assign ara_data = ara_data_q;

	// ------------------------------------------------------------
	// pin drive, low-active open drain
	// ------------------------------------------------------------
	wire logic fs_on    = loc_fs || rem_fs;   // RL5 RL14
	wire logic sec_on   = loc_sec || rem_sec; // RL12 RL14
	wire logic alert_on = (alert_q != ALERT_IDLE) && alarm_any || (alert_q == ALERT_LATCHED); // RL4
	wire logic pin_on   = second_fs_mode ? sec_on : alert_on; // RL11

	assign failsafe_overtemp_n  = 1'b0;
	assign failsafe_overtemp_oe = fs_on;
	assign alarm_pin_n          = 1'b0;
	assign alarm_pin_oe         = pin_on;
	assign irq                  = alarm_any;

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	logic [7:0] rsel;
	always_comb
	begin
		case (paddr)
			OFS_CONFIG:     rsel = cfg_q;
			OFS_STATUS:     rsel = {1'b0, status_q};
			OFS_MASK:       rsel = {1'b0, mask_q};
			OFS_LOC_HIGH:   rsel = loc_high_q;
			OFS_LOC_LOW:    rsel = loc_low_q;
			OFS_REM_HIGH:   rsel = rem_high_q;
			OFS_REM_LOW:    rsel = rem_low_q;
			OFS_LOC_FS:     rsel = loc_fs_q;
			OFS_REM_FS:     rsel = rem_fs_q;
			OFS_HYST:       rsel = hyst_q;
			OFS_OFFSET:     rsel = offset_q;
			OFS_LOC_RESULT: rsel = loc_res_q;
			OFS_REM_RESULT: rsel = rem_res_q;
			OFS_PINS:       rsel = {5'h00, sec_on, pin_on, fs_on};
			default:        rsel = ZERO8;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= {24'h000000, rsel};
	end

endmodule

// File: verification/temp_alarm_props.sv
// checker on the top ports of temp_alarm_outputs
// assumes one clock domain and the register layout of the package
`timescale 1ns/100ps
module temp_alarm_props
	import temp_alarm_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2a
)
(
	// clock, reset, apb
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	// results and alert answer
	input wire logic        loc_wr,
	input wire logic        rem_wr,
	input wire logic        ara_req,
	input wire logic        ara_ack,
	input wire logic [7:0]  ara_data,
	// pins
	input wire logic        failsafe_overtemp_n,
	input wire logic        failsafe_overtemp_oe,
	input wire logic        alarm_pin_n,
	input wire logic        alarm_pin_oe
);
	logic cfg_q;
	logic acked_q;
	wire  cfg_wr = psel && penable && pwrite && paddr == OFS_CONFIG;
	wire  res_wr = loc_wr || rem_wr;

	always_ff @(posedge core_clk or posedge rst)
		if (rst)
		begin
			cfg_q   <= 1'b0;
			acked_q <= 1'b0;
		end
		else
		begin
			if (cfg_wr)
				cfg_q <= pwdata[CFG_SECOND_FS];
			acked_q <= ara_ack || (acked_q && alarm_pin_oe);
		end

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_pins_low; !failsafe_overtemp_n && !alarm_pin_n; endproperty
	property p_fs_rise; $rose(failsafe_overtemp_oe) |-> $past(res_wr, 2); endproperty
	property p_fs_fall; $fell(failsafe_overtemp_oe) |-> $past(res_wr, 2); endproperty
	property p_sec_rise;
		cfg_q && $past(cfg_q) && $past(cfg_q, 2) && $rose(alarm_pin_oe) |-> $past(res_wr, 2);
	endproperty
	property p_sec_fall;
		cfg_q && $past(cfg_q) && $past(cfg_q, 2) && $fell(alarm_pin_oe) |-> $past(res_wr, 2);
	endproperty
	property p_ack_cause; ara_ack |-> ara_req && alarm_pin_oe && !cfg_q; endproperty
	property p_ara_data; ara_ack |=> ara_data == {DEV_ADDR, 1'b1}; endproperty
	property p_release; !cfg_q && $stable(cfg_q) && $fell(alarm_pin_oe) |-> acked_q; endproperty

	a_pins_low: assert property (p_pins_low)
		else $error("pin driven high");
	a_fs_rise: assert property (p_fs_rise)
		else $error("fail-safe rose without result");
	a_fs_fall: assert property (p_fs_fall)
		else $error("fail-safe fell without result");
	a_sec_rise: assert property (p_sec_rise)
		else $error("second fail-safe rose without result");
	a_sec_fall: assert property (p_sec_fall)
		else $error("second fail-safe fell without result");
	a_ack_cause: assert property (p_ack_cause)
		else $error("alert answer without latched alarm");
	a_ara_data: assert property (p_ara_data)
		else $error("wrong alert answer address");
	a_release: assert property (p_release)
		else $error("alarm released before answer");

	c_ack: cover property (ara_ack);
	c_release: cover property (!cfg_q && $fell(alarm_pin_oe));
	c_fs_fall: cover property ($fell(failsafe_overtemp_oe));
endmodule

bind temp_alarm_outputs temp_alarm_props #(.DEV_ADDR(DEV_ADDR)) u_props (
	.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .loc_wr(loc_wr), .rem_wr(rem_wr), .ara_req(ara_req),
	.ara_ack(ara_ack), .ara_data(ara_data), .failsafe_overtemp_n(failsafe_overtemp_n),
	.failsafe_overtemp_oe(failsafe_overtemp_oe), .alarm_pin_n(alarm_pin_n),
	.alarm_pin_oe(alarm_pin_oe));

// File: verification/alarm_host_model.sv
// host model: pull-ups on both alarm lines and an alert-response master
// assumes the bench raises serve to ask for one alert-response read
`timescale 1ns/100ps
module alarm_host_model
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// bench request
	input  wire logic       serve,
	// device side
	input  wire logic       alarm_pin_n,
	input  wire logic       alarm_pin_oe,
	input  wire logic       failsafe_overtemp_n,
	input  wire logic       failsafe_overtemp_oe,
	input  wire logic       ara_ack,
	input  wire logic [7:0] ara_data,
	output logic            ara_req,
	// observed lines
	output logic            alarm_line,
	output logic            failsafe_overtemp_n_line,
	output logic            served,
	output logic [7:0]      seen_addr
);
	logic grab_q;

	// released lines float up to the pull-up
	assign alarm_line = alarm_pin_oe ? alarm_pin_n : 1'b1;
	assign failsafe_overtemp_n_line = failsafe_overtemp_oe ? failsafe_overtemp_n : 1'b1;

	always_ff @(posedge core_clk or posedge rst)
		if (rst)
		begin
			ara_req   <= 1'b0;
			grab_q    <= 1'b0;
			served    <= 1'b0;
			seen_addr <= 8'h00;
		end
		else
		begin
			grab_q <= ara_req && ara_ack;
			if (grab_q)
				seen_addr <= ara_data;
			served <= serve && (served || grab_q);
			if (ara_req && ara_ack)
				ara_req <= 1'b0;
			else if (serve && !alarm_line && !served && !grab_q)
				ara_req <= 1'b1;
		end
endmodule

// File: verification/temp_alarm_outputs_test.sv
// self-checking bench for temp_alarm_outputs
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/100ps
module temp_alarm_outputs_test;
	import temp_alarm_pkg::*;
	localparam logic [6:0] DEV_ADDR = 7'h35; // arbitrary value
	logic        core_clk, rst, psel, penable, pwrite, loc_wr, rem_wr, conv_start, diode_open, serve;
	logic [7:0]  paddr, loc_raw, rem_raw, ara_data, seen_addr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, ara_req, ara_ack, fs_n, fs_oe, al_n, al_oe, irq;
	logic        alarm_line, failsafe_overtemp_n_line, served;
	int          errors, cmp_count;

	temp_alarm_outputs #(.DEV_ADDR(DEV_ADDR)) dut (.core_clk(core_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .loc_wr(loc_wr), .loc_raw(loc_raw), .rem_wr(rem_wr),
		.rem_raw(rem_raw), .conv_start(conv_start), .diode_open(diode_open), .ara_req(ara_req),
		.ara_ack(ara_ack), .ara_data(ara_data), .failsafe_overtemp_n(fs_n),
		.failsafe_overtemp_oe(fs_oe), .alarm_pin_n(al_n), .alarm_pin_oe(al_oe), .irq(irq));

	alarm_host_model host (.core_clk(core_clk), .rst(rst), .serve(serve), .alarm_pin_n(al_n),
		.alarm_pin_oe(al_oe), .failsafe_overtemp_n(fs_n), .failsafe_overtemp_oe(fs_oe),
		.ara_ack(ara_ack), .ara_data(ara_data), .ara_req(ara_req), .alarm_line(alarm_line),
		.failsafe_overtemp_n_line(failsafe_overtemp_n_line), .served(served), .seen_addr(seen_addr));

	// ----------------
	// tasks
	// ----------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp, what);
	endtask

	task automatic temp(input logic remote, input logic [7:0] v);
		@(posedge core_clk);
		loc_wr <= !remote;
		rem_wr <= remote;
		loc_raw <= v;
		rem_raw <= v;
		@(posedge core_clk);
		loc_wr <= 1'b0;
		rem_wr <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask

	task automatic conv(input logic d);
		@(posedge core_clk);
		conv_start <= 1'b1;
		diode_open <= d;
		@(posedge core_clk);
		conv_start <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask

	task automatic ara();
		int n;
		n = 0;
		serve <= 1'b1;
		while (served !== 1'b1 && n < 40)
		begin
			@(posedge core_clk);
			n++;
		end
		serve <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic calm();
		temp(1'b0, 8'h30);
		temp(1'b1, 8'h30);
		wr(OFS_STATUS, 32'h7f);
		ara();
		repeat (2) @(posedge core_clk);
	endtask

	// expected hysteresis state
	function automatic logic hys(input logic s, input logic [7:0] t, input logic [7:0] lim,
		input logic [7:0] h);
		if ($signed(t) > $signed(lim))
			return 1'b1;
		if ($signed({t[7], t}) <= $signed({lim[7], lim}) - $signed({1'b0, h}))
			return 1'b0;
		return s;
	endfunction

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------
	// sequence
	// ----------------
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial
	begin
		repeat (20000) @(posedge core_clk);
		errors++;
		conclude();
	end

	initial
	begin
		logic [31:0] r;
		logic        e;
		logic [7:0]  t, hy;
		logic        f[2], s[2];
		int          ch;
		int          bit_of[5];
		logic [7:0]  val_of[5];
		logic        rem_of[5];
		bit_of = '{ST_LOC_HIGH, ST_LOC_LOW, ST_REM_HIGH, ST_REM_LOW, ST_OPEN};
		val_of = '{8'h50, 8'h00, 8'h50, 8'h00, 8'h00};
		rem_of = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
		{rst, psel, penable, pwrite, loc_wr, rem_wr, conv_start, diode_open, serve} = 9'h100;
		{paddr, loc_raw, rem_raw, pwdata} = '0;
		errors = 0;
		cmp_count = 0;
		void'($urandom(32'hc1e9286f));
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		rdc(OFS_LOC_FS, 32'h55, "local fail-safe limit");
		rdc(OFS_REM_FS, 32'h55, "remote fail-safe limit");
		rdc(OFS_HYST, 32'h0a, "hysteresis");
		apb(1'b0, 8'h38, 32'h0, r, e);
		chk(e, 1'b1, "unmapped error");
		wr(OFS_OFFSET, 32'h05);
		temp(1'b1, 8'h7e);
		rdc(OFS_REM_RESULT, 32'h7f, "saturated remote");
		chk(failsafe_overtemp_n_line, 1'b0, "remote fail-safe");
		wr(OFS_OFFSET, 32'hfb);
		temp(1'b1, 8'h4f);
		rdc(OFS_REM_RESULT, 32'h4a, "offset remote");
		chk(failsafe_overtemp_n_line, 1'b1, "fail-safe after offset");
		wr(OFS_OFFSET, 32'h00);
		wr(OFS_LOC_HIGH, 32'h46);
		wr(OFS_REM_HIGH, 32'h46);
		for (int i = 0; i < 5; i++)
		begin
			calm();
			if (bit_of[i] == ST_OPEN)
				conv(1'b1);
			else
				temp(rem_of[i], val_of[i]);
			rdc(OFS_STATUS, 32'h1 << bit_of[i], "status event");
			chk(alarm_line, 1'b0, "alarm asserted");
			chk(irq, 1'b1, "irq raised");
			if (bit_of[i] == ST_OPEN)
				conv(1'b0);
			else
				temp(rem_of[i], 8'h30);
			wr(OFS_STATUS, 32'h7f);
			chk(alarm_line, 1'b0, "alarm held before answer");
			ara();
			chk(seen_addr, {DEV_ADDR, 1'b1}, "alert answer");
			repeat (2) @(posedge core_clk);
			chk(alarm_line, 1'b1, "alarm released");
		end
		wr(OFS_MASK, 32'h1 << ST_LOC_HIGH);
		temp(1'b0, 8'h50);
		chk(irq, 1'b0, "masked irq");
		chk(alarm_line, 1'b1, "masked alarm");
		temp(1'b0, 8'h30);
		wr(OFS_MASK, 32'h7f);
		hy = 8'($urandom_range(15, 0));
		wr(OFS_HYST, {24'h0, hy});
		rdc(OFS_HYST, {24'h0, hy}, "hysteresis rewritten");
		wr(OFS_CONFIG, 32'h1 << CFG_SECOND_FS);
		f = '{1'b0, 1'b0};
		s = '{1'b0, 1'b0};
		for (int k = 0; k < 40; k++)
		begin
			ch = $urandom_range(1, 0);
			t = 8'h3c + 8'($urandom_range(30, 0));
			temp(ch[0], t);
			f[ch] = hys(f[ch], t, 8'h55, hy);
			s[ch] = hys(s[ch], t, 8'h46, hy);
			chk(failsafe_overtemp_n_line, !(f[0] | f[1]), "fail-safe pin");
			chk(alarm_line, !(s[0] | s[1]), "second fail-safe pin");
			chk(irq, 1'b0, "irq under full mask");
		end
		conclude();
	end
endmodule
